// ### design/opfc_pkg.sv
// shared constants and types for the oscillator phase and frequency control
package opfc_pkg;

    localparam int          OPFC_NUM_OSC     = 8;
    localparam int          OPFC_OSC_W       = 3;
    localparam int          OPFC_ACC_W       = 32;
    localparam int          OPFC_DEG_W       = 9;
    localparam int          OPFC_TURN_DEG    = 360;
    localparam int          OPFC_LUT_IDX_W   = 6;
    localparam int          OPFC_SINE_W      = 8;
    // clock period and frequency update time, nanoseconds
    localparam int          OPFC_CLK_NS      = 100;
    localparam int          OPFC_FREQ_UPD_NS = 100;
    localparam int          OPFC_UPD_RAW     = OPFC_FREQ_UPD_NS / OPFC_CLK_NS;
    localparam int          OPFC_FREQ_UPD_CYC = (OPFC_UPD_RAW < 1) ? 1 : OPFC_UPD_RAW;
    // tuning word per hertz, scaled by 2^16, for 2^32 accumulator at 10 MHz
    localparam logic [31:0] OPFC_FTW_PER_HZ  = 32'h01ad_7f2a;
    localparam int          OPFC_FTW_SHIFT   = 16;
    // quarter period sine, 16 entries, entry 0 in the low byte
    localparam logic [127:0] OPFC_QSINE = {
        8'h7f, 8'h7e, 8'h7b, 8'h78, 8'h73, 8'h6d, 8'h66, 8'h5e,
        8'h55, 8'h4c, 8'h41, 8'h36, 8'h2b, 8'h1f, 8'h13, 8'h06};
    localparam logic [31:0] OPFC_ACC_RST     = 32'h0000_0000;
    localparam logic [8:0]  OPFC_DEG_RST     = 9'h000;

    typedef enum logic [2:0] {
        OPFC_OP_CLEAR_PHASE = 3'h0,
        OPFC_OP_LOAD_PHASE  = 3'h1,
        OPFC_OP_ADD_PHASE   = 3'h2,
        OPFC_OP_LOAD_FREQ   = 3'h3,
        OPFC_OP_SWEEP_SETUP = 3'h4,
        OPFC_OP_SWEEP_INDEX = 3'h5
    } opfc_op_type;

    typedef struct packed {
        opfc_op_type        op;
        logic               all_osc;
        logic [7:0]         mask;
        logic [2:0]         osc;
        logic [31:0]        arg_a;
        logic [31:0]        arg_b;
    } opfc_cmd_type;

    typedef enum logic [1:0] {
        OPFC_ST_IDLE = 2'b01,
        OPFC_ST_UPD  = 2'b10
    } opfc_state_type;

endpackage

// ### design/opfc_osc_ctrl.sv
// carrier phase and oscillator frequency control for one generator channel
`timescale 1ns/1ps
`default_nettype none

module opfc_osc_ctrl #(
    parameter int NUM_OSC = opfc_pkg::OPFC_NUM_OSC
) (
    input  wire logic                          i_mclk,
    input  wire logic                          i_rst_n,
    input  wire logic                          i_cmd_valid,
    input  wire opfc_pkg::opfc_cmd_type        i_cmd,
    input  wire logic                          i_play_req,
    input  wire logic                          i_play_done,
    input  wire logic [2:0]                    i_sine_osc,
    output logic                               o_cmd_ready,
    output logic                               o_play_go,
    output logic                               o_freq_busy,
    output logic [15:0]                        o_sine_phase,
    output logic signed [7:0]                  o_sine
);
    import opfc_pkg::*;

    // oscillator state
    logic [OPFC_ACC_W-1:0]  acc_r     [NUM_OSC];
    logic [OPFC_ACC_W-1:0]  acc_nxt   [NUM_OSC];
    logic [OPFC_ACC_W-1:0]  ftw_r     [NUM_OSC];
    logic [OPFC_ACC_W-1:0]  ftw_nxt   [NUM_OSC];
    logic [31:0]            sw_start_r   [NUM_OSC];
    logic [31:0]            sw_start_nxt [NUM_OSC];
    logic [31:0]            sw_inc_r     [NUM_OSC];
    logic [31:0]            sw_inc_nxt   [NUM_OSC];

    // control state
    opfc_state_type         state_r;
    opfc_state_type         state_nxt;
    logic [7:0]             cnt_r;
    logic [7:0]             cnt_nxt;
    logic [2:0]             upd_osc_r;
    logic [2:0]             upd_osc_nxt;
    logic [31:0]            upd_hz_r;
    logic [31:0]            upd_hz_nxt;
    logic [8:0]             off_r;
    logic [8:0]             off_nxt;
    logic [8:0]             pend_r;
    logic [8:0]             pend_nxt;
    logic                   ready_r;
    logic                   ready_nxt;
    logic                   go_r;
    logic                   go_nxt;
    logic                   busy_r;
    logic                   busy_nxt;
    logic [15:0]            ph_r;
    logic [15:0]            ph_nxt;
    logic signed [7:0]      sine_r;
    logic signed [7:0]      sine_nxt;

    // decoded command
    logic                   take;
    logic                   is_freq;
    logic [7:0]             clr_mask;
    logic [8:0]             arg_deg;
    logic [63:0]            sweep_prod;
    logic [31:0]            sweep_hz;
    logic signed [63:0]     ftw_prod;
    logic [31:0]            ftw_new;
    logic                   ftw_we;
    logic [9:0]             deg_sum;
    logic [9:0]             pend_sum;
    logic [24:0]            off_turn;
    logic [15:0]            phase_sum;
    logic [3:0]             q_idx;
    logic [7:0]             q_val;

    assign take    = i_cmd_valid && ready_r;
    assign is_freq = (i_cmd.op == OPFC_OP_LOAD_FREQ) || (i_cmd.op == OPFC_OP_SWEEP_INDEX);
    assign arg_deg = 9'(i_cmd.arg_a % 32'(OPFC_TURN_DEG));

    // clear all when all_osc is set, otherwise only the oscillators in the mask
    always_comb begin
        clr_mask = 8'h00;
        if (take && i_cmd.op == OPFC_OP_CLEAR_PHASE) begin
            clr_mask = i_cmd.all_osc ? 8'hff : i_cmd.mask;
        end
    end

    assign sweep_prod = i_cmd.arg_a * sw_inc_r[i_cmd.osc];
    assign sweep_hz   = sw_start_r[i_cmd.osc] + sweep_prod[31:0];

    // hertz to tuning word, signed frequencies allowed
    assign ftw_prod = $signed(upd_hz_r) * $signed({32'h0000_0000, OPFC_FTW_PER_HZ});
    assign ftw_new  = ftw_prod[OPFC_FTW_SHIFT +: OPFC_ACC_W];
    assign ftw_we   = (state_r == OPFC_ST_UPD) && (cnt_r == 8'h01);

    // frequency update sequencing
    always_comb begin
        state_nxt   = state_r;
        cnt_nxt     = cnt_r;
        upd_osc_nxt = upd_osc_r;
        upd_hz_nxt  = upd_hz_r;
        case (state_r)
            OPFC_ST_IDLE: begin
                if (take && is_freq) begin
                    state_nxt   = OPFC_ST_UPD;
                    cnt_nxt     = 8'(OPFC_FREQ_UPD_CYC);
                    upd_osc_nxt = i_cmd.osc;
                    upd_hz_nxt  = (i_cmd.op == OPFC_OP_LOAD_FREQ) ? i_cmd.arg_a : sweep_hz;
                end
            end
            OPFC_ST_UPD: begin
                // update ends after one update time
                cnt_nxt = cnt_r - 8'h01;
                if (cnt_r == 8'h01) begin
                    state_nxt = OPFC_ST_IDLE;
                end
            end
            default: begin
                state_nxt = OPFC_ST_IDLE;
            end
        endcase
    end

    generate
        for (genvar g = 0; g < NUM_OSC; g++) begin : g_osc
            always_comb begin
                sw_start_nxt[g] = sw_start_r[g];
                sw_inc_nxt[g]   = sw_inc_r[g];
                ftw_nxt[g]      = ftw_r[g];
                if (take && i_cmd.op == OPFC_OP_SWEEP_SETUP && i_cmd.osc == 3'(g)) begin
                    sw_start_nxt[g] = i_cmd.arg_a;
                    sw_inc_nxt[g]   = i_cmd.arg_b;
                end
                if (ftw_we && upd_osc_r == 3'(g)) begin
                    ftw_nxt[g] = ftw_new;
                end
                if (clr_mask[g]) begin
                    acc_nxt[g] = OPFC_ACC_RST;
                end else begin
                    acc_nxt[g] = acc_r[g] + ftw_r[g];
                end
            end

            always_ff @(posedge i_mclk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    acc_r[g]      <= OPFC_ACC_RST;
                    ftw_r[g]      <= OPFC_ACC_RST;
                    sw_start_r[g] <= 32'h0000_0000;
                    sw_inc_r[g]   <= 32'h0000_0000;
                end else begin
                    acc_r[g]      <= acc_nxt[g];
                    ftw_r[g]      <= ftw_nxt[g];
                    sw_start_r[g] <= sw_start_nxt[g];
                    sw_inc_r[g]   <= sw_inc_nxt[g];
                end
            end
        end
    endgenerate

    // phase offset and pending increment
    always_comb begin
        off_nxt  = off_r;
        pend_nxt = pend_r;
        pend_sum = {1'b0, pend_r};
        if (take && i_cmd.op == OPFC_OP_ADD_PHASE) begin
            pend_sum = {1'b0, pend_r} + {1'b0, arg_deg};
            if (pend_sum >= 10'(OPFC_TURN_DEG)) begin
                pend_sum = pend_sum - 10'(OPFC_TURN_DEG);
            end
        end
        pend_nxt = pend_sum[8:0];
        deg_sum  = {1'b0, off_r} + pend_sum;
        if (deg_sum >= 10'(OPFC_TURN_DEG)) begin
            deg_sum = deg_sum - 10'(OPFC_TURN_DEG);
        end
        if (take && i_cmd.op == OPFC_OP_LOAD_PHASE) begin
            off_nxt = arg_deg;
        end
        // added phase held until a playback ends; a loaded phase applies at once unless a playback ends in the same cycle
        if (i_play_done) begin
            off_nxt  = deg_sum[8:0];
            pend_nxt = OPFC_DEG_RST;
        end
    end

    // handshakes toward the sequencer and player
    always_comb begin
        ready_nxt = (state_nxt == OPFC_ST_IDLE);
        busy_nxt  = (state_nxt == OPFC_ST_UPD);
        go_nxt = i_play_req && !go_r && (state_nxt == OPFC_ST_IDLE);
        // playback go held until the frequency update is done
    end

    // offset to turn fraction, quarter-wave lookup
    always_comb begin
        off_turn  = {off_r, 16'h0000} / 25'(OPFC_TURN_DEG);
        phase_sum = acc_r[i_sine_osc][31:16] + off_turn[15:0];
        ph_nxt    = phase_sum;
        q_idx     = phase_sum[14] ? ~phase_sum[13:10] : phase_sum[13:10];
        q_val     = OPFC_QSINE[q_idx * 8 +: 8];
        sine_nxt  = phase_sum[15] ? -$signed(q_val) : $signed(q_val);
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r   <= OPFC_ST_IDLE;
            cnt_r     <= 8'h00;
            upd_osc_r <= 3'h0;
            upd_hz_r  <= 32'h0000_0000;
            off_r     <= OPFC_DEG_RST;
            pend_r    <= OPFC_DEG_RST;
            ready_r   <= 1'b0;
            go_r      <= 1'b0;
            busy_r    <= 1'b0;
            ph_r      <= 16'h0000;
            sine_r    <= 8'sh00;
        end else begin
            state_r   <= state_nxt;
            cnt_r     <= cnt_nxt;
            upd_osc_r <= upd_osc_nxt;
            upd_hz_r  <= upd_hz_nxt;
            off_r     <= off_nxt;
            pend_r    <= pend_nxt;
            ready_r   <= ready_nxt;
            go_r      <= go_nxt;
            busy_r    <= busy_nxt;
            ph_r      <= ph_nxt;
            sine_r    <= sine_nxt;
        end
    end

    assign o_cmd_ready  = ready_r;
    assign o_play_go    = go_r;
    assign o_freq_busy  = busy_r;
    assign o_sine_phase = ph_r;
    assign o_sine       = sine_r;

endmodule

`default_nettype wire

// ### sim/opfc_player_model.sv
// playback engine model: fixed play length, then a done pulse
`timescale 1ns/1ps
`default_nettype none
module opfc_player_model #(
    parameter int LEN = 6
) (
    input  wire logic i_mclk,
    input  wire logic i_rst_n,
    input  wire logic i_go,
    output var  logic o_done
);
    int cnt;
    always @(negedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt    <= 0;
            o_done <= 1'b0;
        end else begin
            o_done <= (cnt == 1);
            if (i_go) begin
                cnt <= LEN;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule
`default_nettype wire

// ### sim/opfc_osc_ctrl_assertions.sv
// port checks for the phase and frequency control
`timescale 1ns/1ps
`default_nettype none
module opfc_osc_ctrl_checker
    import opfc_pkg::*;
#(
    parameter int NUM_OSC = OPFC_NUM_OSC
) (
    input wire logic         i_mclk,
    input wire logic         i_rst_n,
    input wire logic         i_cmd_valid,
    input wire opfc_cmd_type i_cmd,
    input wire logic         i_play_req,
    input wire logic         o_cmd_ready,
    input wire logic         o_play_go,
    input wire logic         o_freq_busy
);
    wire logic is_f = i_cmd.op == OPFC_OP_LOAD_FREQ || i_cmd.op == OPFC_OP_SWEEP_INDEX;
    wire logic took_f = i_cmd_valid && o_cmd_ready && is_f;
    wire logic took_o = i_cmd_valid && o_cmd_ready && !is_f;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    a_freq_fixed: assert property (took_f |=> o_freq_busy && !o_cmd_ready
        ##1 !o_freq_busy && o_cmd_ready) else $error("frequency update length wrong");
    a_busy_cause: assert property ($rose(o_freq_busy) |-> $past(took_f))
        else $error("busy without frequency command");
    a_other_free: assert property (took_o |=> o_cmd_ready && !o_freq_busy)
        else $error("phase command stalled the bus");
    a_ready_back: assert property (!o_cmd_ready |=> o_cmd_ready)
        else $error("ready low too long");
    a_busy_once: assert property (o_freq_busy |=> !o_freq_busy)
        else $error("frequency update longer than one cycle");
    a_go_busy: assert property (o_play_go |-> !o_freq_busy)
        else $error("playback started during update");
    a_go_pulse: assert property (o_play_go |=> !o_play_go)
        else $error("playback go longer than one cycle");
    a_go_cause: assert property (o_play_go |-> $past(i_play_req))
        else $error("playback go without request");
    a_req_go: assert property ($rose(i_play_req) |-> ##[1:3] o_play_go)
        else $error("playback request not answered");
endmodule
bind opfc_osc_ctrl opfc_osc_ctrl_checker #(.NUM_OSC(NUM_OSC)) u_chk (.i_mclk, .i_rst_n,
    .i_cmd_valid, .i_cmd, .i_play_req, .o_cmd_ready, .o_play_go, .o_freq_busy);
`default_nettype wire

// ### sim/opfc_osc_ctrl_bench.sv
// self-checking bench for the phase and frequency control
`timescale 1ns/1ps
`default_nettype none
module opfc_osc_ctrl_bench;
    import opfc_pkg::*;
    logic              i_mclk;
    logic              i_rst_n;
    logic              i_cmd_valid;
    opfc_cmd_type      i_cmd;
    logic              i_play_req;
    logic              i_play_done;
    logic [2:0]        i_sine_osc;
    logic              o_cmd_ready;
    logic              o_play_go;
    logic              o_freq_busy;
    logic [15:0]       o_sine_phase;
    logic signed [7:0] o_sine;
    int                failures;
    int                num_checks;
    opfc_osc_ctrl dut (.i_mclk, .i_rst_n, .i_cmd_valid, .i_cmd, .i_play_req, .i_play_done,
        .i_sine_osc, .o_cmd_ready, .o_play_go, .o_freq_busy, .o_sine_phase, .o_sine);
    opfc_player_model #(.LEN(6)) u_player (.i_mclk, .i_rst_n, .i_go(o_play_go),
        .o_done(i_play_done));
    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cmd(input opfc_op_type op, input logic [7:0] mask, input logic [2:0] osc,
                       input logic [31:0] a, input logic [31:0] b = 32'h0);
        @(negedge i_mclk);
        i_cmd = '{op, mask == 8'h00, mask, osc, a, b};
        i_cmd_valid = 1'b1;
        for (int n = 0; n < 20 && o_cmd_ready !== 1'b1; n++) @(negedge i_mclk);
        chk("cmd_ready", 32'h1, {31'h0, o_cmd_ready});
        @(negedge i_mclk);
        i_cmd_valid = 1'b0;
    endtask
    task automatic freq_case(input logic [2:0] osc, input longint hz, input logic [7:0] mask);
        logic [31:0] ftw;
        ftw = 32'((hz * longint'(OPFC_FTW_PER_HZ)) >>> OPFC_FTW_SHIFT);
        i_sine_osc = osc;
        cmd(OPFC_OP_CLEAR_PHASE, mask, 3'h0, 32'h0);
        @(negedge i_mclk);
        chk("phase_at_clear", 32'h0, {16'h0, o_sine_phase});
        repeat (4) @(negedge i_mclk);
        chk("phase_after_4", {16'h0, 16'((ftw * 32'd4) >> 16)}, {16'h0, o_sine_phase});
    endtask
    task automatic play();
        @(negedge i_mclk);
        i_play_req = 1'b1;
        for (int n = 0; n < 8 && o_play_go !== 1'b1; n++) @(negedge i_mclk);
        chk("play_go", 32'h1, {31'h0, o_play_go});
        i_play_req = 1'b0;
        for (int n = 0; n < 20 && i_play_done !== 1'b1; n++) @(negedge i_mclk);
        chk("play_done", 32'h1, {31'h0, i_play_done});
    endtask
    task automatic hold_case();
        @(negedge i_mclk);
        i_cmd = '{OPFC_OP_LOAD_FREQ, 1'b0, 8'h00, 3'h6, 32'd500000, 32'h0};
        i_cmd_valid = 1'b1;
        i_play_req = 1'b1;
        @(negedge i_mclk);
        i_cmd_valid = 1'b0;
        chk("go_held", 32'h0, {31'h0, o_play_go});
        chk("busy_on", 32'h1, {31'h0, o_freq_busy});
        @(negedge i_mclk);
        chk("go_after", 32'h1, {31'h0, o_play_go});
        chk("busy_off", 32'h0, {31'h0, o_freq_busy});
        i_play_req = 1'b0;
        for (int n = 0; n < 20 && i_play_done !== 1'b1; n++) @(negedge i_mclk);
        chk("hold_done", 32'h1, {31'h0, i_play_done});
    endtask
    task automatic phase_case();
        i_sine_osc = 3'h2;
        cmd(OPFC_OP_LOAD_PHASE, 8'h00, 3'h0, 32'd405);
        cmd(OPFC_OP_ADD_PHASE, 8'h00, 3'h0, 32'd270);
        cmd(OPFC_OP_ADD_PHASE, 8'h00, 3'h0, 32'd180);
        repeat (2) @(negedge i_mclk);
        chk("loaded_phase", 32'h2000, {16'h0, o_sine_phase});
        play();
        chk("phase_held", 32'h2000, {16'h0, o_sine_phase});
        @(negedge i_mclk);
        chk("added_phase", 32'h6000, {16'h0, o_sine_phase});
        chk("sine_135", {24'h0, OPFC_QSINE[63:56]}, {24'h0, o_sine});
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        failures++;
        end_of_test();
    end
    initial begin
        failures = 0;
        num_checks = 0;
        i_rst_n = 1'b0;
        i_cmd_valid = 1'b0;
        i_cmd = '0;
        i_play_req = 1'b0;
        i_sine_osc = 3'h2;
        repeat (4) @(negedge i_mclk);
        i_rst_n = 1'b1;
        repeat (2) @(negedge i_mclk);
        chk("sine_rest", {24'h0, OPFC_QSINE[7:0]}, {24'h0, o_sine});
        cmd(OPFC_OP_LOAD_FREQ, 8'h00, 3'h0, 32'd1000000);
        cmd(OPFC_OP_LOAD_FREQ, 8'h00, 3'h1, 32'd2000000);
        freq_case(3'h0, 1000000, 8'h00);
        freq_case(3'h0, 1000000, 8'h00);
        freq_case(3'h1, 2000000, 8'h02);
        i_sine_osc = 3'h0;
        cmd(OPFC_OP_CLEAR_PHASE, 8'h02, 3'h0, 32'h0);
        @(negedge i_mclk);
        chk("osc0_kept", 32'h1, {31'h0, o_sine_phase !== 16'h0});
        cmd(OPFC_OP_SWEEP_SETUP, 8'h00, 3'h3, 32'd1000000, 32'd200);
        cmd(OPFC_OP_SWEEP_SETUP, 8'h00, 3'h4, 32'd3000000, 32'd0);
        cmd(OPFC_OP_SWEEP_INDEX, 8'h00, 3'h3, 32'd5000);
        freq_case(3'h3, 2000000, 8'h08);
        cmd(OPFC_OP_SWEEP_INDEX, 8'h00, 3'h4, 32'd0);
        freq_case(3'h4, 3000000, 8'h10);
        phase_case();
        cmd(OPFC_OP_LOAD_FREQ, 8'h00, 3'h5, 32'd1000000);
        play();
        hold_case();
        end_of_test();
    end
endmodule
`default_nettype wire
